// file: logic/rov_pkg.sv
// Purpose: shared constants and types for the residual overvoltage stage
// Assumes: one 40 MHz clock, AXI4-Lite register access
// Notes: magnitudes in 0.01 % of nominal_voltage, line-to-line scale
package rov_pkg;
    // ============================================================
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int SAMPLE_PERIOD_MS = 5;
    localparam int SAMPLE_PERIOD_CYCLES =
        SAMPLE_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    // two missed updates before flagging, one late sample is tolerated
    localparam logic [19:0] SAMPLE_LOSS_DEFAULT =
        20'(2 * SAMPLE_PERIOD_CYCLES);
    // ============================================================
    // scaling and settings
    localparam int GROUPS = 8;
    localparam logic [15:0] THR_DEFAULT = 16'h07D0;
    localparam logic [15:0] THR_MIN = 16'h0064;
    localparam logic [15:0] THR_MAX = 16'h26AC;
    localparam logic [6:0] PCT_SCALE = 7'h64;
    localparam logic [6:0] RESET_RATIO = 7'h61;
    localparam logic [19:0] CALC_DIV = 20'h00003;
    localparam logic [15:0] MAG_SAT = 16'hFFFF;
    localparam logic [4:0] ROOT_LAST_BIT = 5'h13;
    localparam logic [4:0] DIV_LAST_BIT = 5'h17;
    // ============================================================
    // register map
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATE = 8'h04;
    localparam logic [7:0] OFF_MAG = 8'h08;
    localparam logic [7:0] OFF_RATIO = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h14;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h18;
    localparam logic [7:0] OFF_THR_BASE = 8'h20;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int IRQ_W = 5;
    localparam int IRQ_START = 0;
    localparam int IRQ_BLOCKED = 1;
    localparam int IRQ_RELEASE = 2;
    localparam int IRQ_NO_SOURCE = 3;
    localparam int IRQ_SAMPLE_LOST = 4;
    // ============================================================
    // types
    typedef enum logic [2:0] {MODE_ON = 3'h0, MODE_BLOCKED = 3'h1,
        MODE_TEST = 3'h2, MODE_TEST_BLOCKED = 3'h3,
        MODE_OFF = 3'h4} mode_t;
    typedef enum logic [1:0] {FORCE_NORMAL = 2'h0, FORCE_START = 2'h1,
        FORCE_TRIP = 2'h2, FORCE_BLOCKED = 2'h3} force_t;
    typedef enum logic [1:0] {SRC_NONE = 2'h0, SRC_CALC = 2'h1,
        SRC_THIRD = 2'h2, SRC_FOURTH = 2'h3} src_t;
    typedef enum logic [1:0] {FSM_IDLE = 2'h0, FSM_ROOT = 2'h1,
        FSM_RATIO = 2'h3, FSM_DECIDE = 2'h2} fsm_t;
    typedef struct packed {
        logic [19:0] rsvd; logic ln_conn; logic ch4_u0; logic ch3_u0;
        logic force_en; logic allow_mode; src_t src; force_t force_to;
        mode_t mode;
    } ctrl_t;
    typedef struct packed {
        logic [20:0] rsvd; logic [2:0] group; logic no_src; src_t src;
        logic test; logic trip; logic blocked; logic start; logic pickup;
    } status_t;
    typedef struct packed {logic signed [17:0] re; logic signed [17:0] im;
    } phasor_t;
    typedef struct packed {
        logic sample_valid; phasor_t [2:0] phase;
        logic [15:0] third; logic [15:0] fourth;
    } meas_t;
    typedef struct packed {
        logic awvalid; logic [7:0] awaddr; logic wvalid;
        logic [31:0] wdata; logic [3:0] wstrb; logic bready;
        logic arvalid; logic [7:0] araddr; logic rready;
    } axi_req_t;
    typedef struct packed {
        logic awready; logic wready; logic bvalid; logic [1:0] bresp;
        logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    } axi_rsp_t;
    typedef struct packed {
        fsm_t state; ctrl_t ctrl; logic [GROUPS-1:0][15:0] thr;
        logic [IRQ_W-1:0] irq_st; logic [IRQ_W-1:0] irq_en;
        logic aw_held; logic [7:0] aw_addr; logic w_held;
        logic [31:0] w_data; logic [3:0] w_strb; axi_rsp_t rsp;
        logic [39:0] sq; logic [19:0] root; logic [4:0] cnt;
        logic [16:0] rem; logic [23:0] quo; logic [15:0] mag;
        logic [15:0] thr_used; logic [23:0] ratio; src_t src_now;
        logic [2:0] group; logic blk; logic pickup; logic start;
        logic blocked; logic trip; logic irq; logic [19:0] idle_cnt;
    } state_t;
endpackage : rov_pkg

// file: logic/residual_overvoltage_stage.sv
// Purpose: pick-up stage of the residual_overvoltage_stage
// Assumes: front end and blocking matrix run on core_clk
// Notes on behaviour
// - calc source is one third of phasor sum
// - result scaled so full fault equals 100 %
// - source select: none, calc, third, fourth
// - third/fourth usable only in residual mode
// - five node modes, default on, gated globally
// - force status overrides start, blocked and trip when force_en is set, except in mode off
// - mode, force, source are static settings
// - pick up when magnitude exceeds threshold
// - release only below 97 % of threshold
// - ratio magnitude/threshold recomputed each sample
// - threshold 0.01 % steps, default 20.00
// - threshold from active group, live update
// - unselected falls back to calc or none
// - block input picks start or blocked
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module residual_overvoltage_stage #(
    parameter logic [19:0] SAMPLE_LOSS_CYCLES = rov_pkg::SAMPLE_LOSS_DEFAULT
) (
    input wire logic core_clk, // 40 MHz
    input wire logic rst, // async, active high
    input wire rov_pkg::axi_req_t axi_req, // AXI4-Lite master side
    output rov_pkg::axi_rsp_t axi_rsp, // AXI4-Lite slave side
    input wire rov_pkg::meas_t meas, // front end magnitudes
    input wire logic block_in, // blocking matrix input
    input wire logic [2:0] active_group, // current setting_group
    output logic pickup, // pick-up condition
    output logic start, // start signal
    output logic blocked, // blocked signal
    output logic trip, // trip, forced only
    output logic irq // level interrupt
);
    // ============================================================
    // state and helpers
    rov_pkg::state_t st;
    rov_pkg::state_t next_st;
    rov_pkg::mode_t eff_mode;
    rov_pkg::src_t sel_src;
    rov_pkg::status_t status;
    logic signed [19:0] sum_re;
    logic signed [19:0] sum_im;
    logic [19:0] trial;
    logic [39:0] trial_sq;
    logic [16:0] shifted;
    logic [19:0] root_div;
    logic [22:0] mag_pct;
    logic [22:0] thr_release;
    localparam int IRQ_W_L = rov_pkg::IRQ_W;
    logic [IRQ_W_L-1:0] events;
    logic [IRQ_W_L-1:0] clr;
    logic [31:0] wmerged;
    logic [31:0] rword;
    logic rerr;
    logic werr;
    logic pick_n;
    logic blk_n;

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    function automatic logic [15:0] clamp_thr(input logic [15:0] v);
        if (v < rov_pkg::THR_MIN) begin
            return rov_pkg::THR_MIN;
        end
        if (v > rov_pkg::THR_MAX) begin
            return rov_pkg::THR_MAX;
        end
        return v;
    endfunction : clamp_thr

    assign axi_rsp = st.rsp;
    assign pickup = st.pickup;
    assign start = st.start;
    assign blocked = st.blocked;
    assign trip = st.trip;
    assign irq = st.irq;

    // ============================================================
    // combinational next state
    always_comb begin
        next_st = st;
        eff_mode = st.ctrl.allow_mode ? st.ctrl.mode : rov_pkg::MODE_ON;
        sum_re = 20'(meas.phase[0].re) + 20'(meas.phase[1].re)
            + 20'(meas.phase[2].re);
        sum_im = 20'(meas.phase[0].im) + 20'(meas.phase[1].im)
            + 20'(meas.phase[2].im);
        trial = st.root | (20'h00001 << st.cnt);
        trial_sq = trial * trial;
        shifted = {st.rem[15:0], st.quo[23]};
        root_div = st.root / rov_pkg::CALC_DIV;
        mag_pct = 23'(st.mag) * 23'(rov_pkg::PCT_SCALE);
        thr_release = 23'(st.thr_used) * 23'(rov_pkg::RESET_RATIO);
        events = '0;
        clr = '0;
        pick_n = 1'b0;
        blk_n = 1'b0;
        status = '0;
        status.group = st.group;
        status.no_src = st.src_now == rov_pkg::SRC_NONE;
        status.src = st.src_now;
        status.test = eff_mode == rov_pkg::MODE_TEST
            || eff_mode == rov_pkg::MODE_TEST_BLOCKED;
        status.trip = st.trip;
        status.blocked = st.blocked;
        status.start = st.start;
        status.pickup = st.pickup;
        // source choice, unselected falls back to calc when ln_conn, else none
        case (st.ctrl.src)
            rov_pkg::SRC_CALC: sel_src = rov_pkg::SRC_CALC;
            rov_pkg::SRC_THIRD: sel_src = st.ctrl.ch3_u0 ?
                rov_pkg::SRC_THIRD : rov_pkg::SRC_NONE;
            rov_pkg::SRC_FOURTH: sel_src = st.ctrl.ch4_u0 ?
                rov_pkg::SRC_FOURTH : rov_pkg::SRC_NONE;
            default: sel_src = st.ctrl.ln_conn ?
                rov_pkg::SRC_CALC : rov_pkg::SRC_NONE;
        endcase

        // -------- register read
        rerr = 1'b0;
        case (axi_req.araddr)
            rov_pkg::OFF_CTRL: rword = st.ctrl;
            rov_pkg::OFF_STATE: rword = status;
            rov_pkg::OFF_MAG: rword = 32'(st.mag);
            rov_pkg::OFF_RATIO: rword = 32'(st.ratio);
            rov_pkg::OFF_IRQ_STATUS: rword = 32'(st.irq_st);
            rov_pkg::OFF_IRQ_ENABLE: rword = 32'(st.irq_en);
            default: begin
                rword = '0;
                rerr = 1'b1;
                if (axi_req.araddr[7:5] == rov_pkg::OFF_THR_BASE[7:5]
                    && axi_req.araddr[1:0] == 2'h0) begin
                    rword = 32'(st.thr[axi_req.araddr[4:2]]);
                    rerr = 1'b0;
                end
            end
        endcase
        if (st.rsp.rvalid && axi_req.rready) begin
            next_st.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && st.rsp.arready) begin
            next_st.rsp.rvalid = 1'b1;
            next_st.rsp.rdata = rword;
            next_st.rsp.rresp = rerr ? rov_pkg::RESP_SLVERR
                : rov_pkg::RESP_OKAY;
        end
        next_st.rsp.arready = !next_st.rsp.rvalid;

        // -------- register write
        if (st.rsp.bvalid && axi_req.bready) begin
            next_st.rsp.bvalid = 1'b0;
        end
        if (axi_req.awvalid && st.rsp.awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && st.rsp.wready) begin
            next_st.w_held = 1'b1;
            next_st.w_data = axi_req.wdata;
            next_st.w_strb = axi_req.wstrb;
        end
        werr = 1'b0;
        wmerged = '0;
        if (st.aw_held && st.w_held && !st.rsp.bvalid) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.rsp.bvalid = 1'b1;
            case (st.aw_addr)
                rov_pkg::OFF_CTRL: begin
                    // static, untouched by setting_group changes
                    wmerged = merge(st.ctrl, st.w_data, st.w_strb);
                    next_st.ctrl = rov_pkg::ctrl_t'(wmerged);
                    next_st.ctrl.rsvd = '0;
                    if (!(next_st.ctrl.mode inside {rov_pkg::MODE_ON,
                        rov_pkg::MODE_BLOCKED, rov_pkg::MODE_TEST,
                        rov_pkg::MODE_TEST_BLOCKED, rov_pkg::MODE_OFF}))
                    begin
                        next_st.ctrl.mode = st.ctrl.mode;
                    end
                end
                rov_pkg::OFF_IRQ_CLEAR: begin
                    wmerged = merge('0, st.w_data, st.w_strb);
                    clr = wmerged[IRQ_W_L-1:0];
                end
                rov_pkg::OFF_IRQ_ENABLE: begin
                    wmerged = merge(32'(st.irq_en), st.w_data, st.w_strb);
                    next_st.irq_en = wmerged[IRQ_W_L-1:0];
                end
                default: begin
                    werr = 1'b1;
                    if (st.aw_addr[7:5] == rov_pkg::OFF_THR_BASE[7:5]
                        && st.aw_addr[1:0] == 2'h0) begin
                        werr = 1'b0;
                        wmerged = merge(32'(st.thr[st.aw_addr[4:2]]),
                            st.w_data, st.w_strb);
                        next_st.thr[st.aw_addr[4:2]] =
                            clamp_thr(wmerged[15:0]);
                    end
                end
            endcase
            next_st.rsp.bresp = werr ? rov_pkg::RESP_SLVERR
                : rov_pkg::RESP_OKAY;
        end
        next_st.rsp.awready = !next_st.aw_held && !next_st.rsp.bvalid;
        next_st.rsp.wready = !next_st.w_held && !next_st.rsp.bvalid;

        // -------- sample processing
        next_st.idle_cnt = st.idle_cnt + 20'h00001;
        if (meas.sample_valid) begin
            next_st.idle_cnt = '0;
        end else if (st.idle_cnt == SAMPLE_LOSS_CYCLES) begin
            events[rov_pkg::IRQ_SAMPLE_LOST] = 1'b1;
        end
        case (st.state)
            rov_pkg::FSM_IDLE: begin
                if (meas.sample_valid) begin
                    // block sampled at the start of the cycle
                    next_st.blk = block_in;
                    next_st.group = active_group;
                    next_st.thr_used = st.thr[active_group];
                    next_st.src_now = sel_src;
                    next_st.state = rov_pkg::FSM_RATIO;
                    next_st.cnt = rov_pkg::DIV_LAST_BIT;
                    next_st.rem = '0;
                    case (sel_src)
                        rov_pkg::SRC_CALC: begin
                            next_st.sq = 40'(sum_re * sum_re)
                                + 40'(sum_im * sum_im);
                            next_st.root = '0;
                            next_st.cnt = rov_pkg::ROOT_LAST_BIT;
                            next_st.state = rov_pkg::FSM_ROOT;
                        end
                        rov_pkg::SRC_THIRD: next_st.mag = meas.third;
                        rov_pkg::SRC_FOURTH: next_st.mag = meas.fourth;
                        default: begin
                            next_st.mag = '0;
                            events[rov_pkg::IRQ_NO_SOURCE] = 1'b1;
                        end
                    endcase
                    next_st.quo = 24'(next_st.mag) * 24'(rov_pkg::PCT_SCALE);
                end
            end
            rov_pkg::FSM_ROOT: begin
                // one result bit per cycle, no big divider needed
                if (trial_sq <= st.sq) begin
                    next_st.root = trial;
                end
                next_st.cnt = st.cnt - 5'h01;
                if (st.cnt == '0) begin
                    next_st.state = rov_pkg::FSM_RATIO;
                    // one count above the divider marks the load step,
                    // stale quotient or zero magnitude cannot stall it
                    next_st.cnt = rov_pkg::DIV_LAST_BIT + 5'h01;
                end
            end
            rov_pkg::FSM_RATIO: begin
                if (st.cnt > rov_pkg::DIV_LAST_BIT) begin
                    // phases already scaled to phase nominal, /3 lands
                    // a full earth fault on 100 % line-to-line
                    next_st.mag = (root_div > 20'(rov_pkg::MAG_SAT))
                        ? rov_pkg::MAG_SAT : root_div[15:0];
                    next_st.quo = 24'(next_st.mag)
                        * 24'(rov_pkg::PCT_SCALE);
                    next_st.cnt = rov_pkg::DIV_LAST_BIT;
                end else begin
                    next_st.quo = {st.quo[22:0], 1'b0};
                    next_st.rem = shifted;
                    if (shifted >= {1'b0, st.thr_used}) begin
                        next_st.rem = shifted - {1'b0, st.thr_used};
                        next_st.quo[0] = 1'b1;
                    end
                    next_st.cnt = st.cnt - 5'h01;
                    if (st.cnt == '0) begin
                        next_st.state = rov_pkg::FSM_DECIDE;
                    end
                end
            end
            rov_pkg::FSM_DECIDE: begin
                next_st.ratio = st.quo;
                next_st.state = rov_pkg::FSM_IDLE;
                next_st.rem = '0;
                next_st.quo = '0;
                if (st.pickup) begin
                    pick_n = !(mag_pct < thr_release);
                end else begin
                    pick_n = st.mag > st.thr_used;
                end
                blk_n = st.blk || eff_mode == rov_pkg::MODE_BLOCKED
                    || eff_mode == rov_pkg::MODE_TEST_BLOCKED;
                next_st.pickup = pick_n;
                next_st.start = pick_n && !blk_n;
                next_st.blocked = pick_n && blk_n;
                next_st.trip = 1'b0;
                if (st.ctrl.force_en) begin
                    case (st.ctrl.force_to)
                        rov_pkg::FORCE_START: begin
                            next_st.start = 1'b1;
                            next_st.blocked = 1'b0;
                        end
                        rov_pkg::FORCE_TRIP: begin
                            next_st.start = 1'b1;
                            next_st.blocked = 1'b0;
                            next_st.trip = 1'b1;
                        end
                        rov_pkg::FORCE_BLOCKED: begin
                            next_st.start = 1'b0;
                            next_st.blocked = 1'b1;
                        end
                        default: ;
                    endcase
                end
                if (eff_mode == rov_pkg::MODE_OFF) begin
                    next_st.pickup = 1'b0;
                    next_st.start = 1'b0;
                    next_st.blocked = 1'b0;
                    next_st.trip = 1'b0;
                end
                events[rov_pkg::IRQ_START] = next_st.start && !st.start;
                events[rov_pkg::IRQ_BLOCKED] =
                    next_st.blocked && !st.blocked;
                events[rov_pkg::IRQ_RELEASE] = st.pickup && !next_st.pickup;
            end
            default: next_st.state = rov_pkg::FSM_IDLE;
        endcase

        // -------- interrupts, set beats clear
        next_st.irq_st = (st.irq_st & ~clr) | events;
        next_st.irq = |(next_st.irq_st & next_st.irq_en);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.thr <= {rov_pkg::GROUPS{rov_pkg::THR_DEFAULT}};
        end else begin
            st <= next_st;
        end
    end

    // ============================================================
    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [41:0] lo_sq;
    logic [41:0] hi_sq;
    assign lo_sq = 42'(st.mag) * 42'(st.mag) * 42'h9;
    assign hi_sq = (42'(st.mag) * 42'h3 + 42'h3)
        * (42'(st.mag) * 42'h3 + 42'h3);

    calc_root_a: assert property (
        (st.state == rov_pkg::FSM_DECIDE && st.src_now == rov_pkg::SRC_CALC
        && st.mag != rov_pkg::MAG_SAT)
        |-> (lo_sq <= 42'(st.sq)) && (42'(st.sq) < hi_sq))
        else $error("calculated magnitude off");
    ratio_value_a: assert property (
        st.state == rov_pkg::FSM_DECIDE
        |=> st.ratio == 24'(mag_pct) / 24'(st.thr_used))
        else $error("ratio not magnitude over threshold");
    pickup_set_a: assert property (
        (st.state == rov_pkg::FSM_DECIDE && !st.pickup
        && eff_mode != rov_pkg::MODE_OFF && st.mag > st.thr_used)
        |=> pickup)
        else $error("pick-up missed above threshold");
    hyst_hold_a: assert property (
        (st.state == rov_pkg::FSM_DECIDE && st.pickup
        && eff_mode != rov_pkg::MODE_OFF && !(mag_pct < thr_release))
        |=> pickup)
        else $error("pick-up released inside hysteresis");
    mode_off_a: assert property (
        (st.state == rov_pkg::FSM_DECIDE && eff_mode == rov_pkg::MODE_OFF)
        |=> (!pickup && !start && !trip)[*3])
        else $error("outputs active in mode off");
    start_block_a: assert property (
        !(start && blocked))
        else $error("start and blocked together");
    force_trip_a: assert property (
        (st.state == rov_pkg::FSM_DECIDE && st.ctrl.force_en
        && st.ctrl.force_to == rov_pkg::FORCE_TRIP
        && eff_mode != rov_pkg::MODE_OFF) |=> trip && start)
        else $error("forced trip not shown");
    static_ctrl_a: assert property (
        !(st.aw_held && st.w_held && !st.rsp.bvalid)
        |=> $stable(st.ctrl))
        else $error("static setting changed without write");
    source_pick_a: assert property (
        (st.state == rov_pkg::FSM_IDLE && meas.sample_valid
        && st.ctrl.src == rov_pkg::SRC_NONE && !st.ctrl.ln_conn)
        |=> st.src_now == rov_pkg::SRC_NONE
        && st.irq_st[rov_pkg::IRQ_NO_SOURCE])
        else $error("unselected source without phases not reported");
    irq_level_a: assert property (
        $rose(|(st.irq_st & st.irq_en)) |-> irq)
        else $error("interrupt not raised");
    pickup_c: cover property (
        st.state == rov_pkg::FSM_DECIDE ##1 $rose(start));
    blocked_c: cover property ($rose(blocked));
    release_c: cover property ($fell(pickup) ##[1:8] !pickup);
endmodule : residual_overvoltage_stage

// file: verif/meas_source.sv
// Purpose: front end model, one sample per request
// Assumes: requests spaced wider than the stage's decision time
// Notes: unused channel toggles so it never looks settled
`timescale 1ns/10ps
module meas_source (
    input wire logic core_clk, // clock
    input wire logic rst, // reset, active high
    input wire logic req, // send one sample
    input wire logic [15:0] mag, // residual magnitude to send
    output rov_pkg::meas_t meas // to the stage
);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meas <= '0;
        end else begin
            meas.sample_valid <= req;
            meas.third <= mag;
            meas.fourth <= ~meas.fourth;
            // one phase carries the whole sum, so a third of it is mag
            meas.phase[0].re <= 18'(mag) * 18'h00003;
            meas.phase[0].im <= 18'h00000;
            meas.phase[2:1] <= '0;
        end
    end
endmodule : meas_source

// file: verif/residual_overvoltage_stage_bench.sv
// Purpose: self-checking bench of the residual overvoltage stage
// Assumes: meas_source feeds samples, AXI4-Lite for settings
// Notes: threshold 1000 puts the release edge at exactly 970
`timescale 1ns/10ps
module residual_overvoltage_stage_bench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic block_in = 1'b0;
    logic req = 1'b0;
    logic [15:0] mag = 16'h0000;
    logic [2:0] active_group = 3'h0;
    logic pickup, start, blocked, trip, irq;
    logic [31:0] rd;
    logic [1:0] rs;
    rov_pkg::axi_req_t axi_req = '0;
    rov_pkg::axi_rsp_t axi_rsp;
    rov_pkg::meas_t meas;
    int err_total = 0;
    int num_checks = 0;
    int seed = 60418;
    int pk = 0;
    int off = 0;
    int thr = 1000;
    initial forever #12.5 core_clk = ~core_clk;
    meas_source fe (.core_clk(core_clk), .rst(rst), .req(req), .mag(mag),
        .meas(meas));
    residual_overvoltage_stage #(.SAMPLE_LOSS_CYCLES(20'h000C8)) uut (
        .core_clk(core_clk), .rst(rst), .axi_req(axi_req),
        .axi_rsp(axi_rsp), .meas(meas), .block_in(block_in),
        .active_group(active_group), .pickup(pickup), .start(start),
        .blocked(blocked), .trip(trip), .irq(irq));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge core_clk);
        axi_req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d,
            wstrb: 4'hF, bready: 1'b1, default: '0};
        do begin
            @(posedge core_clk);
            n++;
            if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
        end while (axi_rsp.bvalid !== 1'b1 && n < 50);
        axi_req.bready <= 1'b0;
        rs = axi_rsp.bresp;
        if (n >= 50) begin err_total++; report_and_stop(); end
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        int n = 0;
        @(posedge core_clk);
        axi_req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
        do begin
            @(posedge core_clk);
            n++;
            if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
        end while (axi_rsp.rvalid !== 1'b1 && n < 50);
        axi_req.rready <= 1'b0;
        rd = axi_rsp.rdata;
        rs = axi_rsp.rresp;
        if (n >= 50) begin err_total++; report_and_stop(); end
    endtask : rdr
    task automatic sample(input logic [15:0] m, input logic b, input bit c);
        logic [3:0] e;
        logic [3:0] o;
        @(posedge core_clk);
        mag <= m;
        block_in <= b;
        req <= 1'b1;
        @(posedge core_clk);
        req <= 1'b0;
        // decision lands by sample edge +46 at worst
        repeat (50) @(posedge core_clk);
        pk = (off == 0) && (pk != 0 ? m * 100 >= thr * 97 : m > thr);
        e = {1'b0, pk[0] & b, pk[0] & ~b, pk[0]};
        o = {trip, blocked, start, pickup};
        if (c) check(32'(e), 32'(o));
    endtask : sample
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        rdr(8'h00); check(rd, 32'h0);
        rdr(8'h28); check(rd, 32'(rov_pkg::THR_DEFAULT));
        rdr(8'h40); check({rd[29:0], rs}, {30'h0, rov_pkg::RESP_SLVERR});
        wr(8'h24, 32'h1); rdr(8'h24); check(rd, 32'h64);
        wr(8'h20, 32'd1000); wr(8'h00, 32'h2C0); wr(8'h18, 32'h1);
        sample(16'd1000, 1'b0, 1'b1); sample(16'd1001, 1'b0, 1'b1);
        check(32'(irq), 32'h1);
        sample(16'd970, 1'b0, 1'b1); sample(16'd969, 1'b0, 1'b1);
        wr(8'h14, 32'h1); repeat (2) @(posedge core_clk);
        check(32'(irq), 32'h0);
        $display("threshold and interrupt test done");
        for (int i = 0; i < 8; i++)
            sample(16'(940 + ($random(seed) & 127)), 1'($random(seed)), 1'b1);
        wr(8'h00, 32'h2C4); off = 1; sample(16'd5000, 1'b0, 1'b1);
        off = 0; wr(8'h00, 32'h3D0); sample(16'd0, 1'b0, 1'b0);
        check(32'(trip), 32'h1);
        wr(8'h00, 32'hA20); sample(16'd1200, 1'b0, 1'b1);
        rdr(8'h08); check(rd, 32'd1200);
        rdr(8'h0C); check(rd, 32'd120);
        active_group <= 3'h1; thr = 100; sample(16'd120, 1'b0, 1'b1);
        rdr(8'h08); check(rd, 32'd120);
        rdr(8'h00); check(rd, 32'hA20);
        wr(8'h10, 32'h1F); check(32'(rs), 32'(rov_pkg::RESP_SLVERR));
        wr(8'h00, 32'h0); sample(16'd0, 1'b0, 1'b1);
        rdr(8'h10); check(32'(rd[rov_pkg::IRQ_NO_SOURCE]), 32'h1);
        $display("mode, force, source and group test done");
        report_and_stop();
    end
endmodule : residual_overvoltage_stage_bench
